// ---- rtl/swu_pkg.sv ----
/*
  Constants and types for the single-wire UART write slave.
  Assumes a 100 MHz device clock and a host that keeps to the documented baud range.
*/
package swu_pkg;
  // Clock and baud range
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_MIN = 9000;
  localparam int MAX_BIT_CYC = CLK_HZ / BAUD_MIN;
  localparam int BAUD_MAX_DIV = 16;
  localparam int BIT_W = 16;
  localparam int MEAS_W = 19;
  localparam int TMR_W = 24;
  localparam logic [BIT_W-1:0] MIN_BIT_CYC = BIT_W'(BAUD_MAX_DIV);
  localparam logic [MEAS_W-1:0] GLITCH_CYC = MEAS_W'(16);
  // Bit-time figures
  localparam logic [7:0] TIMEOUT_BITS = 8'h3f;
  localparam logic [7:0] RECOVER_BITS = 8'h0c;
  localparam int SYNC_MEAS_SHIFT = 2;
  localparam logic [1:0] SYNC_FALLS = 2'h2;
  localparam logic [3:0] SYNC_FIRST_IDX = 4'h4;
  localparam logic [7:0] SYNC_PRELOAD = 8'ha0;
  localparam logic [3:0] START_IDX = 4'h0;
  localparam logic [3:0] STOP_IDX = 4'h9;
  // Datagram layout
  localparam logic [2:0] BYTE_ADDR = 3'h1;
  localparam logic [2:0] BYTE_REG = 3'h2;
  localparam logic [2:0] LAST_BYTE_WR = 3'h7;
  localparam logic [2:0] LAST_BYTE_RD = 3'h3;
  localparam int WRITE_BIT = 7;
  localparam logic [7:0] REPLY_ADDR = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  typedef enum logic [2:0] {
    SWU_IDLE = 3'b000,
    SWU_SYNC = 3'b001,
    SWU_BITS = 3'b011,
    SWU_GAP = 3'b010,
    SWU_RECOVER = 3'b110
  } swu_state_type;

  typedef struct packed {
    logic [6:0] index;
    logic [31:0] data;
  } swu_wr_type;
endpackage : swu_pkg

// ---- rtl/swu_write_slave.sv ----
/*
  Single-wire UART write slave: baud detection from the sync nibble, write datagram
  parsing, timeout, glitch and error recovery, and a counter of accepted writes.
  Assumes the line and address pins are synchronous to ref_clk_in; the line is
  shared half-duplex and the read reply path lives elsewhere.
*/
`timescale 1ns/1ns
module swu_write_slave
  import swu_pkg::*;
#(
  parameter logic [BIT_W-1:0] MAX_BIT_CYC_P = BIT_W'(MAX_BIT_CYC)
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic line_in,
  input wire logic address_select_low_pin_in,
  input wire logic address_select_high_pin_in,
  output logic line_out,
  output logic line_oe_out,
  output logic wr_valid_out,
  output swu_wr_type wr_out,
  output logic [7:0] datagram_count_out,
  output logic comm_error_out
);

  function automatic logic [7:0] crc_byte(input logic [7:0] crc_in, input logic [7:0] data_in);
    logic [7:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++)
    begin
      if (c[7] ^ data_in[i])
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_byte

  swu_state_type state_reg;
  logic line_prev_reg;
  logic [MEAS_W-1:0] meas_reg;
  logic [1:0] falls_reg;
  logic [BIT_W-1:0] bit_len_reg;
  logic [BIT_W-1:0] good_bit_reg;
  logic [BIT_W-1:0] phase_reg;
  logic [3:0] idx_reg;
  logic [7:0] shift_reg;
  logic [2:0] byte_num_reg;
  logic [7:0] crc_reg;
  logic [7:0] addr_byte_reg;
  logic [7:0] reg_byte_reg;
  logic [31:0] data_reg;
  logic [TMR_W-1:0] gap_tmr_reg;
  logic [TMR_W-1:0] idle_tmr_reg;

  logic fall;
  logic [7:0] rx_byte;
  logic sample_now;
  logic byte_done;
  logic frame_err;
  logic [MEAS_W-1:0] meas_bits;
  logic [BIT_W-1:0] meas_len;
  logic sync_done;
  logic sync_err;
  logic gap_timeout;
  logic idle_done;
  logic [2:0] last_byte;
  logic dgram_end;
  logic crc_ok;
  logic [7:0] node_address;
  logic accept_wr;
  logic any_err;

  assign fall = line_prev_reg & ~line_in;
  assign node_address = {6'h00, address_select_high_pin_in, address_select_low_pin_in};
  assign sample_now = (state_reg == SWU_BITS) && (phase_reg == '0);
  assign rx_byte = {line_in, shift_reg[7:1]};
  assign frame_err = sample_now &&
    (((idx_reg == START_IDX) && line_in) || ((idx_reg == STOP_IDX) && !line_in));
  assign byte_done = sample_now && (idx_reg == STOP_IDX) && line_in;

  // Four bit times span from start edge to the bit2/bit3 edge
  assign meas_bits = meas_reg >> SYNC_MEAS_SHIFT;
  assign meas_len = meas_bits[BIT_W-1:0];
  assign sync_done = (state_reg == SWU_SYNC) && fall && (falls_reg == SYNC_FALLS - 2'h1);
  assign sync_err = (state_reg == SWU_SYNC) && (
    ((falls_reg == 2'h0) && line_in && (meas_reg < GLITCH_CYC)) ||
    (meas_reg >= {MAX_BIT_CYC_P, 2'b00, 1'b0}) ||
    (sync_done && ((meas_len < MIN_BIT_CYC) || (meas_len > MAX_BIT_CYC_P))));

  // Timeout measured against the last good datagram's bit time
  assign gap_timeout = (state_reg == SWU_GAP) &&
    (gap_tmr_reg > TMR_W'(TIMEOUT_BITS * good_bit_reg));
  assign idle_done = idle_tmr_reg >= TMR_W'(RECOVER_BITS * good_bit_reg);

  // Reads are four bytes; replies addressed to the master are full length
  assign last_byte = (reg_byte_reg[WRITE_BIT] || (addr_byte_reg == REPLY_ADDR)) ?
    LAST_BYTE_WR : LAST_BYTE_RD;
  assign dgram_end = byte_done && (byte_num_reg >= BYTE_REG) && (byte_num_reg == last_byte);
  // At the stop sample the shifter holds the whole checksum byte
  assign crc_ok = (shift_reg == crc_reg);
  assign accept_wr = dgram_end && crc_ok && (addr_byte_reg == node_address) &&
    reg_byte_reg[WRITE_BIT];
  assign any_err = frame_err || sync_err || gap_timeout || (dgram_end && !crc_ok);

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      line_prev_reg <= 1'b1;
    else
      line_prev_reg <= line_in;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_reg <= SWU_IDLE;
    else if (any_err)
      state_reg <= SWU_RECOVER;
    else
    begin
      unique case (state_reg)
        SWU_IDLE:
          if (fall)
            state_reg <= SWU_SYNC;
        SWU_SYNC:
          if (sync_done)
            state_reg <= SWU_BITS;
        SWU_BITS:
          if (dgram_end)
            state_reg <= SWU_IDLE;
          else if (byte_done)
            state_reg <= SWU_GAP;
        SWU_GAP:
          if (fall)
            state_reg <= SWU_BITS;
        SWU_RECOVER:
          if (idle_done && line_in)
            state_reg <= SWU_IDLE;
        default:
          state_reg <= SWU_RECOVER;
      endcase
    end
  end

  // Sync measurement
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meas_reg <= '0;
      falls_reg <= 2'h0;
      bit_len_reg <= '0;
    end
    else if (state_reg == SWU_IDLE)
    begin
      meas_reg <= MEAS_W'(1);
      falls_reg <= 2'h0;
    end
    else if (state_reg == SWU_SYNC)
    begin
      meas_reg <= meas_reg + MEAS_W'(1);
      if (fall)
        falls_reg <= falls_reg + 2'h1;
      if (sync_done)
        bit_len_reg <= meas_len;
    end
  end

  // Bit sampling at mid-bit
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_reg <= '0;
      idx_reg <= START_IDX;
      shift_reg <= '0;
    end
    else if (sync_done)
    begin
      phase_reg <= meas_len >> 1;
      idx_reg <= SYNC_FIRST_IDX;
      shift_reg <= SYNC_PRELOAD;
    end
    else if ((state_reg == SWU_GAP) && fall)
    begin
      phase_reg <= bit_len_reg >> 1;
      idx_reg <= START_IDX;
    end
    else if (state_reg == SWU_BITS)
    begin
      if (sample_now)
      begin
        phase_reg <= bit_len_reg - BIT_W'(1);
        idx_reg <= idx_reg + 4'h1;
        if ((idx_reg != START_IDX) && (idx_reg != STOP_IDX))
          shift_reg <= rx_byte;
      end
      else
        phase_reg <= phase_reg - BIT_W'(1);
    end
  end

  // Byte assembly and checksum
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      byte_num_reg <= '0;
      crc_reg <= CRC_INIT;
      addr_byte_reg <= '0;
      reg_byte_reg <= '0;
      data_reg <= '0;
    end
    else if (sync_done)
    begin
      byte_num_reg <= '0;
      crc_reg <= CRC_INIT;
      reg_byte_reg <= '0;
      addr_byte_reg <= '0;
    end
    else if (byte_done && !dgram_end)
    begin
      byte_num_reg <= byte_num_reg + 3'h1;
      crc_reg <= crc_byte(crc_reg, shift_reg);
      if (byte_num_reg == BYTE_ADDR)
        addr_byte_reg <= shift_reg;
      else if (byte_num_reg == BYTE_REG)
        reg_byte_reg <= shift_reg;
      else if (byte_num_reg > BYTE_REG)
        data_reg <= {data_reg[23:0], shift_reg};
    end
  end

  // Inter-byte timeout
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      gap_tmr_reg <= '0;
    else if (fall && ((state_reg == SWU_IDLE) || (state_reg == SWU_GAP)))
      gap_tmr_reg <= '0;
    else if (state_reg != SWU_IDLE)
      gap_tmr_reg <= gap_tmr_reg + TMR_W'(1);
  end

  // Idle time before the line is trusted again
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      idle_tmr_reg <= '0;
    else if ((state_reg != SWU_RECOVER) || !line_in)
      idle_tmr_reg <= '0;
    else if (!idle_done)
      idle_tmr_reg <= idle_tmr_reg + TMR_W'(1);
  end

  // Bit time of the last clean datagram feeds the timeouts
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      good_bit_reg <= MAX_BIT_CYC_P;
    else if (dgram_end && crc_ok)
      good_bit_reg <= bit_len_reg;
  end

  // Write strobe only after the checksum byte checks out
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_valid_out <= 1'b0;
      wr_out <= '0;
    end
    else
    begin
      wr_valid_out <= accept_wr;
      if (accept_wr)
        wr_out <= '{index: reg_byte_reg[6:0], data: data_reg};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      datagram_count_out <= COUNT_RESET;
    else if (accept_wr)
      datagram_count_out <= datagram_count_out + 8'h01;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      comm_error_out <= 1'b0;
    else
      comm_error_out <= any_err && (state_reg != SWU_RECOVER);
  end

  // Receive only: the wire is left to the host and the reply path
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      line_out <= 1'b1;
      line_oe_out <= 1'b0;
    end
    else
    begin
      line_out <= 1'b1;
      line_oe_out <= 1'b0;
    end
  end

endmodule : swu_write_slave

// ---- test/swu_write_slave_checker.sv ----
/* Port checker for the single-wire write slave.
   Assumes only the slave's own ports; bound below. */
`timescale 1ns/1ns
module swu_write_slave_checker
  import swu_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe_out,
  input wire logic wr_valid_out,
  input wire swu_wr_type wr_out,
  input wire logic [7:0] datagram_count_out,
  input wire logic comm_error_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  a_wire_released:
    assert property (line_out && !line_oe_out) else $error("slave drives wire");
  a_valid_spacing:
    assert property (wr_valid_out |=> !wr_valid_out [*8]) else $error("write pulse too long");
  a_count_step:
    assert property (wr_valid_out |-> datagram_count_out == $past(datagram_count_out) + 8'h01)
      else $error("count not stepped");
  a_count_hold:
    assert property (!wr_valid_out |-> $stable(datagram_count_out)) else $error("count moved");
  a_data_hold:
    assert property (!wr_valid_out |-> $stable(wr_out)) else $error("payload moved");
  a_stop_high:
    assert property (wr_valid_out |-> $past(line_in)) else $error("write without stop");
  a_error_quiet:
    assert property (comm_error_out |=> (!comm_error_out && !wr_valid_out) [*8])
      else $error("activity during recovery");
  a_no_clash:
    assert property (!(wr_valid_out && comm_error_out)) else $error("write and error");
endmodule : swu_write_slave_checker
bind swu_write_slave swu_write_slave_checker u_swu_write_slave_checker (.ref_clk_in, .rst_in,
  .line_in, .line_out, .line_oe_out, .wr_valid_out, .wr_out, .datagram_count_out,
  .comm_error_out);

// ---- test/swu_host_model.sv ----
/* Host UART model on the shared wire.
   Assumes the bench calls its tasks at falling edges. */
`timescale 1ns/1ns
module swu_host_model
(
  input wire logic ref_clk_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic bits(input logic v, input int n);
    line_out = v;
    repeat (n) @(negedge ref_clk_in);
  endtask : bits
  task automatic pulse(input int n);
    @(negedge ref_clk_in);
    bits(1'b0, n);
    line_out = 1'b1;
  endtask : pulse
  task automatic send_frame(input logic [1:0] a, input logic [7:0] idx,
    input logic [31:0] d, input int b, input int n, input logic bad);
    logic [7:0] q [8];
    logic [7:0] c;
    q = '{8'ha5, {6'h00, a}, idx, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
    c = 8'h00;
    for (int i = 0; i < n - 1; i++)
      for (int j = 0; j < 8; j++)
        c = (c[7] ^ q[i][j]) ? ((c << 1) ^ 8'h07) : (c << 1);
    q[n - 1] = c ^ {8{bad}};
    @(negedge ref_clk_in);
    for (int i = 0; i < n; i++)
    begin
      bits(1'b0, b);
      for (int j = 0; j < 8; j++)
        bits(q[i][j], b);
      bits(1'b1, b);
    end
  endtask : send_frame
endmodule : swu_host_model

// ---- test/swu_write_slave_test.sv ----
/* Self-checking bench for the single-wire write slave.
   Assumes the host model alone drives the wire; idle level high. */
`timescale 1ns/1ns
module swu_write_slave_test;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic host_line, oe, dout, valid, err;
  logic [38:0] wr;
  logic [7:0] cnt;
  wire line;
  int n_errors = 0;
  int n_checks = 0;
  int exp_cnt = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  assign line = oe ? dout : host_line;
  // Short bit-time ceiling keeps the run brief
  swu_write_slave #(.MAX_BIT_CYC_P(16'h0190)) u_swu_write_slave (.ref_clk_in, .rst_in,
    .line_in(line), .address_select_low_pin_in(sel_lo), .address_select_high_pin_in(sel_hi),
    .line_out(dout), .line_oe_out(oe), .wr_valid_out(valid), .wr_out(wr),
    .datagram_count_out(cnt), .comm_error_out(err));
  swu_host_model u_swu_host_model (.ref_clk_in, .line_out(host_line));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : check
  task automatic watch(input int n, output logic v, output logic e);
    v = 1'b0;
    e = 1'b0;
    repeat (n)
    begin
      @(posedge ref_clk_in);
      #1;
      v |= valid;
      e |= err;
    end
  endtask : watch
  task automatic go(input logic [1:0] a, input logic [7:0] idx, input logic [31:0] d,
    input int b, input int n, input logic bad, input logic ev, input logic ee);
    logic v;
    logic e;
    fork
      u_swu_host_model.send_frame(a, idx, d, b, n, bad);
      watch(n * 10 * b + 8 + (n < 8 ? 70 * b : 0), v, e);
    join
    check(v === ev, "write pulse");
    check(e === ee, "error pulse");
    if (ev)
    begin
      exp_cnt++;
      check(wr === {idx[6:0], d}, "payload");
    end
    check(cnt === exp_cnt[7:0], "count");
    u_swu_host_model.bits(1'b1, 13 * b);
  endtask : go
  task automatic t_addr;
    for (int i = 0; i < 4; i++)
    begin
      sel_lo = i[0];
      sel_hi = i[1];
      go(i[1:0], 8'h90, 32'h8123_4567 + i, 20, 8, 1'b0, 1'b1, 1'b0);
    end
    $display("test addr done");
  endtask : t_addr
  task automatic t_refuse;
    go(2'h1, 8'h90, 32'h0000_0001, 20, 8, 1'b0, 1'b0, 1'b0);
    go(2'h3, 8'h10, 32'h0, 20, 4, 1'b0, 1'b0, 1'b0);
    go(2'h3, 8'h91, 32'hffff_0000, 20, 8, 1'b1, 1'b0, 1'b1);
    go(2'h3, 8'h91, 32'h00ff_ff00, 20, 8, 1'b0, 1'b1, 1'b0);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_baud;
    // Slower rate stays far above 15 percent of the last
    go(2'h3, 8'hff, 32'hdead_0001, 40, 8, 1'b0, 1'b1, 1'b0);
    go(2'h3, 8'h80, 32'h0bad_cafe, 16, 8, 1'b0, 1'b1, 1'b0);
    $display("test baud done");
  endtask : t_baud
  task automatic t_glitch;
    logic v;
    logic e;
    fork
      u_swu_host_model.pulse(10);
      watch(40, v, e);
    join
    check(e === 1'b1 && v === 1'b0, "glitch");
    u_swu_host_model.bits(1'b1, 13 * 16);
    go(2'h3, 8'h85, 32'h5a5a_a5a5, 16, 8, 1'b0, 1'b1, 1'b0);
    $display("test glitch done");
  endtask : t_glitch
  task automatic t_timeout;
    go(2'h3, 8'h90, 32'h0, 16, 2, 1'b0, 1'b0, 1'b1);
    go(2'h3, 8'h92, 32'h7777_1111, 16, 8, 1'b0, 1'b1, 1'b0);
    $display("test timeout done");
  endtask : t_timeout
  initial
  begin
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    check(cnt === 8'h00 && wr === '0 && valid === 1'b0 && err === 1'b0, "reset");
    check(oe === 1'b0 && dout === 1'b1, "wire reset");
    $display("test reset done");
    t_addr();
    t_refuse();
    t_baud();
    t_glitch();
    t_timeout();
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk_in);
    n_errors++;
    $display("mismatch %0t run too long", $time);
    summarize();
  end
endmodule : swu_write_slave_test
